// [ach_defs.vh]
/*
 * ach_defs.vh: register offsets, field positions, reset values and timing
 * counts for the converter control block.
 * Assumes a 250 MHz system clock and a 32-bit classic Wishbone slave port.
 */
`ifndef ACH_DEFS_VH
`define ACH_DEFS_VH

// clock rate
`define ACH_CLK_MHZ 250

// register byte offsets
`define ACH_REG_STATUS 8'h00
`define ACH_REG_CONV_LEN 8'h04
`define ACH_REG_RESULT 8'h08
`define ACH_REG_IRQ_STAT 8'h0C
`define ACH_REG_IRQ_MASK 8'h10

// status register fields
`define ACH_ST_BUSY 0
`define ACH_ST_CAL 1
`define ACH_ST_PD 2
`define ACH_ST_REF_WARN 3
`define ACH_ST_MODE_LO 4
`define ACH_ST_MODE_HI 5
`define ACH_ST_MASTER 6

// interrupt fields
`define ACH_IRQ_DONE 0
`define ACH_IRQ_RDERR 1
`define ACH_IRQ_CAL 2
`define ACH_IRQ_W 3
`define ACH_IRQ_MASK_RST 3'h0

// interface mode codes
`define ACH_MODE_SERIAL 2'h3

// result width and serial bit count
`define ACH_RES_W 18
`define ACH_BITS_DONE 5'h12

// timing: figures in ns, counts in cycles rounded up
`define ACH_T_CONV_NS 400
`define ACH_T_CAL_NS 1000
`define ACH_T_RDERR_NS 20
`define ACH_T_SCLK_HALF_NS 8
`define ACH_CONV_CYC ((`ACH_T_CONV_NS * `ACH_CLK_MHZ + 999) / 1000)
`define ACH_CAL_CYC ((`ACH_T_CAL_NS * `ACH_CLK_MHZ + 999) / 1000)
`define ACH_RDERR_CYC ((`ACH_T_RDERR_NS * `ACH_CLK_MHZ + 999) / 1000)
`define ACH_SCLK_HALF_CYC ((`ACH_T_SCLK_HALF_NS * `ACH_CLK_MHZ + 999) / 1000)

`endif

// [ach_sync.v]
/*
 * ach_sync.v: bank of two-stage synchronisers, one per input bit.
 * Assumes every bit arrives from outside the clk_i domain.
 */
module ach_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    input wire clk_i,
    input wire rst_i,
    input wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);

    genvar gi;

    // two flops per bit; first stage feeds only the second
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
            reg meta_ff;
            reg stable_ff;
            always @(posedge clk_i) begin
                if (rst_i) begin
                    meta_ff <= RST_VAL[gi];
                    stable_ff <= RST_VAL[gi];
                end else begin
                    meta_ff <= async_i[gi];
                    stable_ff <= meta_ff;
                end
            end
            assign sync_o[gi] = stable_ff;
        end
    endgenerate

endmodule // ach_sync

// [ach_conv_ctrl.v]
/*
 * ach_conv_ctrl.v: conversion sequencing, busy and calibration, output bus
 * enables, serial master/slave shifting and a Wishbone register file.
 * Assumes all pin inputs are asynchronous to clk_i; the converter core
 * presents its code on sar_code_i by the end of each conversion.
 */
`include "ach_defs.vh"

// Functional notes
// - result bits 14 to 17 are always driven as outputs in every mode.
// - busy rises as soon as a conversion begins.
// - busy stays high until the result is latched in the shift register.
// - result bits 0 to 11 are enabled only while select and read are both low.
// - in slave serial mode the external clock counts only while select is low.
// - a high reset pin returns the block to idle and aborts any conversion.
// - the falling edge of the reset pin starts calibration, shown by busy.
// - power-down lets a running conversion finish and blocks new ones.
// - a falling convert-start edge puts the sampler in hold and converts.
// - the reference sleep input low keeps the internal reference on.
// - the buffer sleep input low keeps the buffer on; it must be low with the internal reference.
// - mode values 0 to 2 select the parallel bus, value 3 the serial port.
// - an unfinished slave read at conversion end pulses the error flag and drops the data.
// - clock source low makes the device serial master, high a slave.
module ach_conv_ctrl (
    input wire clk_i,
    input wire rst_i,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output wire wb_ack_o,
    // pins
    input wire convert_start_n_i,
    input wire cs_n_i,
    input wire rd_n_i,
    input wire adc_reset_i,
    input wire power_down_req_i,
    input wire ref_sleep_i,
    input wire refbuf_sleep_i,
    input wire [1:0] mode_i,
    input wire clock_source_sel_i,
    input wire shift_edge_invert_i,
    input wire sclk_i,
    output reg sclk_o,
    output wire sclk_oe_o,
    output reg [17:0] data_o,
    output wire [17:0] data_oe_o,
    output wire busy_o,
    output wire sample_hold_o,
    output wire ref_enable_o,
    output wire refbuf_enable_o,
    // converter core code and interrupt
    input wire [17:0] sar_code_i,
    output wire irq_o
);

    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_CONV = 2'h1;
    localparam [1:0] ST_CAL = 2'h2;
    localparam integer CONV_RST = `ACH_CONV_CYC;
    localparam integer CAL_LEN = `ACH_CAL_CYC;
    localparam integer RDERR_LEN = `ACH_RDERR_CYC;
    localparam integer SCLK_HALF = `ACH_SCLK_HALF_CYC;

    wire [13:0] pin_async;
    wire [13:0] pin_s;
    wire cnv_n_s;
    wire cs_n_s;
    wire rd_n_s;
    wire arst_s;
    wire pd_s;
    wire ref_sleep_s;
    wire buf_sleep_s;
    wire [1:0] mode_s;
    wire slave_s;
    wire inv_s;
    wire sclk_s;

    reg [1:0] state_ff;
    reg [11:0] cnt_ff;
    reg cnv_prev_ff;
    reg arst_prev_ff;
    reg [11:0] conv_len_ff;
    reg [17:0] result_ff;
    reg [17:0] shift_ff;
    reg [4:0] bit_cnt_ff;
    reg [3:0] rderr_cnt_ff;
    reg sclk_prev_ff;
    reg [3:0] div_ff;
    reg [2:0] irq_stat_ff;
    reg [2:0] irq_mask_ff;
    reg ack_ff;

    wire serial_mode;
    wire out_en;
    wire cnv_fall;
    wire arst_fall;
    wire conv_done;
    wire cal_done;
    wire read_partial;
    wire gated_sclk;
    wire slave_update;
    wire master_run;
    wire master_update;
    wire rderr_evt;
    wire bus_req;
    wire wr_req;
    wire [2:0] irq_evt;
    wire [2:0] irq_clr;
    reg [17:0] nxt_data;
    reg [31:0] nxt_rdata;

    // pin inputs, reset values match idle pin levels
    assign pin_async = {sclk_i, shift_edge_invert_i, clock_source_sel_i,
                        mode_i, refbuf_sleep_i, ref_sleep_i,
                        power_down_req_i, adc_reset_i, rd_n_i, cs_n_i,
                        convert_start_n_i, 2'h0};

    ach_sync #(
        .WIDTH(14),
        .RST_VAL(14'h001C)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(pin_async),
        .sync_o(pin_s)
    );

    assign cnv_n_s = pin_s[2];
    assign cs_n_s = pin_s[3];
    assign rd_n_s = pin_s[4];
    assign arst_s = pin_s[5];
    assign pd_s = pin_s[6];
    assign ref_sleep_s = pin_s[7];
    assign buf_sleep_s = pin_s[8];
    assign mode_s = pin_s[10:9];
    assign slave_s = pin_s[11];
    assign inv_s = pin_s[12];
    assign sclk_s = pin_s[13];

    // mode decode and output window
    assign serial_mode = (mode_s == `ACH_MODE_SERIAL);
    assign out_en = ~cs_n_s & ~rd_n_s;

    // edge detection on synchronised levels
    assign cnv_fall = cnv_prev_ff & ~cnv_n_s;
    assign arst_fall = arst_prev_ff & ~arst_s;
    assign conv_done = (state_ff == ST_CONV) && (cnt_ff == 12'h001) &&
                       ~arst_s;
    assign cal_done = (state_ff == ST_CAL) && (cnt_ff == 12'h001) && ~arst_s;

    always @(posedge clk_i) begin
        if (rst_i) begin
            cnv_prev_ff <= 1'b1;
            arst_prev_ff <= 1'b0;
        end else begin
            cnv_prev_ff <= cnv_n_s;
            arst_prev_ff <= arst_s;
        end
    end

    // conversion and calibration sequencer
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= ST_IDLE;
            cnt_ff <= 12'h000;
        end else if (arst_s) begin
            state_ff <= ST_IDLE;
            cnt_ff <= 12'h000;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (arst_fall) begin
                        state_ff <= ST_CAL;
                        cnt_ff <= CAL_LEN[11:0];
                    end else if (cnv_fall && ~pd_s) begin
                        state_ff <= ST_CONV;
                        cnt_ff <= conv_len_ff;
                    end
                end
                ST_CONV, ST_CAL: begin
                    if (cnt_ff == 12'h001) begin
                        state_ff <= ST_IDLE;
                        cnt_ff <= 12'h000;
                    end else begin
                        cnt_ff <= cnt_ff - 12'h001;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                    cnt_ff <= 12'h000;
                end
            endcase
        end
    end

    // busy covers conversion and calibration
    assign busy_o = (state_ff != ST_IDLE);
    assign sample_hold_o = (state_ff == ST_CONV);

    // reference enables follow the sleep pins
    assign ref_enable_o = ~ref_sleep_s;
    assign refbuf_enable_o = ~buf_sleep_s;

    // serial clocking: slave gated by select, master divided locally
    assign gated_sclk = sclk_s & ~cs_n_s;
    assign slave_update = serial_mode && slave_s && out_en &&
                          (inv_s ? (sclk_prev_ff & ~gated_sclk) :
                                   (~sclk_prev_ff & gated_sclk));
    assign master_run = serial_mode && ~slave_s && out_en &&
                        (bit_cnt_ff != `ACH_BITS_DONE);
    assign master_update = master_run && sclk_o && (div_ff == 4'h1);
    assign read_partial = (bit_cnt_ff != 5'h00) &&
                          (bit_cnt_ff != `ACH_BITS_DONE);
    assign rderr_evt = conv_done && serial_mode && slave_s && read_partial;

    always @(posedge clk_i) begin
        if (rst_i) begin
            sclk_prev_ff <= 1'b0;
            sclk_o <= 1'b0;
            div_ff <= SCLK_HALF[3:0];
        end else begin
            sclk_prev_ff <= gated_sclk;
            if (!master_run) begin
                sclk_o <= 1'b0;
                div_ff <= SCLK_HALF[3:0];
            end else if (div_ff == 4'h1) begin
                sclk_o <= ~sclk_o;
                div_ff <= SCLK_HALF[3:0];
            end else begin
                div_ff <= div_ff - 4'h1;
            end
        end
    end

    assign sclk_oe_o = serial_mode && ~slave_s;

    // result latch and shift register
    always @(posedge clk_i) begin
        if (rst_i) begin
            result_ff <= 18'h00000;
            shift_ff <= 18'h00000;
            bit_cnt_ff <= `ACH_BITS_DONE;
        end else if (arst_s) begin
            bit_cnt_ff <= `ACH_BITS_DONE;
        end else if (conv_done) begin
            result_ff <= sar_code_i;
            shift_ff <= sar_code_i;
            bit_cnt_ff <= 5'h00;
        end else if ((slave_update || master_update) &&
                     (bit_cnt_ff != `ACH_BITS_DONE)) begin
            shift_ff <= {shift_ff[16:0], 1'b0};
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
        end
    end

    // stretched read-incomplete pulse
    always @(posedge clk_i) begin
        if (rst_i) begin
            rderr_cnt_ff <= 4'h0;
        end else if (rderr_evt) begin
            rderr_cnt_ff <= RDERR_LEN[3:0];
        end else if (rderr_cnt_ff != 4'h0) begin
            rderr_cnt_ff <= rderr_cnt_ff - 4'h1;
        end
    end

    // output bus values
    always @* begin
        nxt_data = result_ff;
        if (serial_mode) begin
            nxt_data[10] = shift_ff[17];
            nxt_data[11] = sclk_o;
            nxt_data[12] = master_run;
            nxt_data[13] = (rderr_cnt_ff != 4'h0);
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            data_o <= 18'h00000;
        end else begin
            data_o <= nxt_data;
        end
    end

    // output enables per bit
    genvar gb;
    generate
        for (gb = 0; gb < `ACH_RES_W; gb = gb + 1) begin : g_oe
            if (gb >= 14) begin : g_top
                assign data_oe_o[gb] = 1'b1;
            end else if (gb == 10) begin : g_sdo
                assign data_oe_o[gb] = out_en;
            end else if (gb == 11) begin : g_sck
                assign data_oe_o[gb] = out_en & (sclk_oe_o | ~serial_mode);
            end else if (gb == 12 || gb == 13) begin : g_flag
                assign data_oe_o[gb] = serial_mode | out_en;
            end else if (gb < 3) begin : g_low
                assign data_oe_o[gb] = out_en && (mode_s == 2'h0);
            end else begin : g_mid
                assign data_oe_o[gb] = out_en && ~serial_mode;
            end
        end
    endgenerate

    // wishbone: ack a cycle after request; writes land on the ack edge
    assign bus_req = wb_cyc_i & wb_stb_i;
    assign wr_req = bus_req & wb_we_i & ack_ff;
    assign wb_ack_o = ack_ff;

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= bus_req & ~ack_ff;
        end
    end

    // sticky interrupt status; set beats write-one clear
    assign irq_evt = {cal_done, rderr_evt, conv_done};
    assign irq_clr = (wr_req && wb_adr_i == `ACH_REG_IRQ_STAT && wb_sel_i[0])
                     ? wb_dat_i[2:0] : 3'h0;

    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_ff <= 3'h0;
            irq_mask_ff <= `ACH_IRQ_MASK_RST;
            conv_len_ff <= CONV_RST[11:0];
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_evt;
            if (wr_req && wb_adr_i == `ACH_REG_IRQ_MASK && wb_sel_i[0]) begin
                irq_mask_ff <= wb_dat_i[2:0];
            end
            if (wr_req && wb_adr_i == `ACH_REG_CONV_LEN) begin
                if (wb_sel_i[0]) begin
                    conv_len_ff[7:0] <= wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    conv_len_ff[11:8] <= wb_dat_i[11:8];
                end
            end
        end
    end

    assign irq_o = |(irq_stat_ff & irq_mask_ff);

    // read data mux, unmapped reads zero
    always @* begin
        nxt_rdata = 32'h00000000;
        case (wb_adr_i)
            `ACH_REG_STATUS: begin
                nxt_rdata[`ACH_ST_BUSY] = busy_o;
                nxt_rdata[`ACH_ST_CAL] = (state_ff == ST_CAL);
                nxt_rdata[`ACH_ST_PD] = pd_s;
                nxt_rdata[`ACH_ST_REF_WARN] = ~ref_sleep_s & buf_sleep_s;
                nxt_rdata[`ACH_ST_MODE_HI:`ACH_ST_MODE_LO] = mode_s;
                nxt_rdata[`ACH_ST_MASTER] = ~slave_s;
            end
            `ACH_REG_CONV_LEN: nxt_rdata[11:0] = conv_len_ff;
            `ACH_REG_RESULT: nxt_rdata[17:0] = result_ff;
            `ACH_REG_IRQ_STAT: nxt_rdata[2:0] = irq_stat_ff;
            `ACH_REG_IRQ_MASK: nxt_rdata[2:0] = irq_mask_ff;
            default: nxt_rdata = 32'h00000000;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (bus_req & ~ack_ff) begin
            wb_dat_o <= nxt_rdata;
        end
    end

endmodule // ach_conv_ctrl

// [ach_checker.sv]
/* ach_checker.sv: concurrent checks on the converter control pins.
   Assumes one clock domain and a synchronous active-high reset. */
module ach_checker (
    input wire clk_i,
    input wire rst_i,
    input wire convert_start_n_i,
    input wire cs_n_i,
    input wire rd_n_i,
    input wire adc_reset_i,
    input wire power_down_req_i,
    input wire ref_sleep_i,
    input wire refbuf_sleep_i,
    input wire [1:0] mode_i,
    input wire clock_source_sel_i,
    input wire sclk_oe_o,
    input wire [17:0] data_oe_o,
    input wire busy_o,
    input wire sample_hold_o,
    input wire ref_enable_o,
    input wire refbuf_enable_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // pin, strobe and enable relations
    msb_drive_a: assert property (data_oe_o[17:14] == 4'hF)
        else $error("top result bits not driven");
    busy_start_a: assert property ($fell(convert_start_n_i) && !busy_o
        && !power_down_req_i && !adc_reset_i |-> ##[2:4] busy_o)
        else $error("busy missing after start");
    hold_in_busy_a: assert property (sample_hold_o |-> busy_o)
        else $error("hold outside busy");
    busy_hold_a: assert property (disable iff (rst_i || adc_reset_i)
        $rose(busy_o) |=> busy_o[*8]) else $error("busy dropped early");
    bus_gate_a: assert property (data_oe_o[10:0] != 11'h0
        |-> !$past(cs_n_i, 2) && !$past(rd_n_i, 2))
        else $error("bus enabled without select and read");
    reset_abort_a: assert property (adc_reset_i[*5] |-> !busy_o)
        else $error("busy under reset pin");
    cal_pulse_a: assert property ($fell(adc_reset_i) |-> ##[2:6] busy_o)
        else $error("no calibration pulse");
    pd_block_a: assert property ((power_down_req_i && !adc_reset_i)[*5]
        ##0 !busy_o |=> !busy_o) else $error("start during power-down");
    ref_on_a: assert property ($stable(ref_sleep_i) && $past(ref_sleep_i) ==
        $past(ref_sleep_i, 2) |-> ref_enable_o == !ref_sleep_i)
        else $error("reference enable wrong");
    buf_on_a: assert property ($stable(refbuf_sleep_i) &&
        $past(refbuf_sleep_i) == $past(refbuf_sleep_i, 2)
        |-> refbuf_enable_o == !refbuf_sleep_i) else $error("buffer enable wrong");
    clk_dir_a: assert property ($stable({mode_i, clock_source_sel_i}) &&
        $past({mode_i, clock_source_sel_i}, 2) == {mode_i, clock_source_sel_i}
        |-> sclk_oe_o == (mode_i == 2'h3 && !clock_source_sel_i))
        else $error("serial clock direction wrong");
endmodule // ach_checker

bind ach_conv_ctrl ach_checker ach_checker_i (.clk_i, .rst_i,
    .convert_start_n_i, .cs_n_i, .rd_n_i, .adc_reset_i, .power_down_req_i,
    .ref_sleep_i, .refbuf_sleep_i, .mode_i, .clock_source_sel_i, .sclk_oe_o,
    .data_oe_o, .busy_o, .sample_hold_o, .ref_enable_o, .refbuf_enable_o);

// [ach_host.sv]
/* ach_host.sv: host model driving start, select, read and serial clock.
   Assumes its tasks are called from one bench process. */
module ach_host (
    input wire clk_i,
    input wire serial_i,
    output logic convert_start_n_o,
    output logic cs_n_o,
    output logic rd_n_o,
    output logic sclk_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle levels: strobes high, serial clock parked low outside frames
    initial begin
        convert_start_n_o = 1'b1;
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        sclk_o = 1'b0;
    end
    // falling start edge, held long enough for the pin synchroniser
    task start;
        @(posedge clk_i);
        convert_start_n_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        convert_start_n_o <= 1'b1;
    endtask
    // select and read move together to open or close the bus
    task sel(input logic on);
        @(posedge clk_i);
        cs_n_o <= !on;
        rd_n_o <= !on;
    endtask
    // slave clock only inside the select window, bit taken before each rise
    task shift(input int cnt, output logic [17:0] bits);
        bits = 18'h0;
        for (int i = 0; i < cnt; i++) begin
            repeat (6) @(posedge clk_i);
            bits = {bits[16:0], serial_i};
            sclk_o <= 1'b1;
            repeat (6) @(posedge clk_i);
            sclk_o <= 1'b0;
        end
    endtask
endmodule // ach_host

// [adc_conversion_host_control_test.sv]
/* adc_conversion_host_control_test.sv: self-checking bench for the
   converter control block. Assumes a 250 MHz clock and the host model. */
module adc_conversion_host_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat;
    logic adc_reset = 1'b0, pd = 1'b0, src_sel = 1'b1;
    logic rs = 1'b0, bs = 1'b0, inv = 1'b0;
    logic [3:0] be = 4'hF;
    logic [1:0] mode = 2'h0;
    logic [17:0] code = 18'h2A5A5, bits;
    wire [31:0] wb_rdat;
    wire [17:0] data, data_oe;
    wire ack, sclk_out, sclk_oe, busy, hold, ref_en, buf_en, irq;
    wire start_n, cs_n, rd_n, sclk;
    // released serial line reads inverted, so a late sample shows up
    wire sdo = data_oe[10] ? data[10] : ~data[10];
    int errors = 0, checks = 0, cycles = 0, n;
    ach_conv_ctrl ach_conv_ctrl_i (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(be), .wb_dat_i(wdat), .wb_dat_o(wb_rdat), .wb_ack_o(ack),
        .convert_start_n_i(start_n), .cs_n_i(cs_n), .rd_n_i(rd_n),
        .adc_reset_i(adc_reset), .power_down_req_i(pd), .ref_sleep_i(rs),
        .refbuf_sleep_i(bs), .mode_i(mode), .clock_source_sel_i(src_sel),
        .shift_edge_invert_i(inv), .sclk_i(sclk), .sclk_o(sclk_out),
        .sclk_oe_o(sclk_oe), .data_o(data), .data_oe_o(data_oe), .busy_o(busy),
        .sample_hold_o(hold), .ref_enable_o(ref_en), .refbuf_enable_o(buf_en),
        .sar_code_i(code), .irq_o(irq));
    ach_host ach_host_i (.clk_i(clk_i), .serial_i(sdo),
        .convert_start_n_o(start_n), .cs_n_o(cs_n), .rd_n_o(rd_n),
        .sclk_o(sclk));
    // free-running clock
    initial forever #2 clk_i = ~clk_i;
    // hang guard
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            conclude;
        end
    end
    task conclude;
        if (errors == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    // one classic cycle, held until ack, then released for a cycle
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        rdat = wb_rdat;
        {cyc, stb} <= 2'b00;
        @(posedge clk_i);
    endtask
    // wait for busy to rise, then count its high cycles
    task busy_len(output int len);
        len = 0;
        repeat (20) if (busy !== 1'b1) @(posedge clk_i);
        while (busy === 1'b1 && len < 400) begin
            @(posedge clk_i);
            len++;
        end
    endtask
    task regs_t;
        wb(0, 8'h04, 0); chk(rdat, 32'h64);
        wb(0, 8'h10, 0); chk(rdat, 32'h0);
        wb(0, 8'h40, 0); chk(rdat, 32'h0);
        wb(1, 8'h04, 32'h14); wb(0, 8'h04, 0); chk(rdat, 32'h14);
        be <= 4'h2; wb(1, 8'h04, 32'hF33); be <= 4'hF;
        wb(0, 8'h04, 0); chk(rdat, 32'hF14); wb(1, 8'h04, 32'h14);
    endtask
    // reference and buffer enables in the legal sleep combinations
    task ref_t;
        rs <= 1'b1; bs <= 1'b1; repeat (4) @(posedge clk_i);
        chk(ref_en, 1'b0); chk(buf_en, 1'b0);
        bs <= 1'b0; repeat (4) @(posedge clk_i);
        chk(ref_en, 1'b0); chk(buf_en, 1'b1);
        rs <= 1'b0; repeat (4) @(posedge clk_i);
        chk(ref_en, 1'b1);
    endtask
    task conv_t;
        ach_host_i.start; busy_len(n); chk(n, 20);
        wb(0, 8'h08, 0); chk(rdat, code);
        wb(0, 8'h0C, 0); chk(rdat & 32'h1, 32'h1);
        chk(irq, 1'b0); wb(1, 8'h10, 32'h1); chk(irq, 1'b1);
        wb(1, 8'h0C, 32'h1); chk(irq, 1'b0);
    endtask
    task par_t;
        ach_host_i.sel(1); repeat (6) @(posedge clk_i);
        chk(data, code); chk(data_oe, 18'h3FFFF);
        mode <= 2'h1; repeat (4) @(posedge clk_i);
        chk(data_oe, 18'h3FFF8); mode <= 2'h0;
        ach_host_i.sel(0); repeat (4) @(posedge clk_i);
        chk(data_oe, 18'h3C000);
    endtask
    task pd_t;
        code <= 18'h0F00F; ach_host_i.start; repeat (6) @(posedge clk_i);
        chk(hold, 1'b1);
        pd <= 1'b1; busy_len(n);
        wb(0, 8'h08, 0); chk(rdat, 32'h0F00F);
        ach_host_i.start;
        repeat (10) @(posedge clk_i) chk(busy, 1'b0);
        pd <= 1'b0; repeat (4) @(posedge clk_i);
    endtask
    task rst_t;
        ach_host_i.start; repeat (8) @(posedge clk_i);
        adc_reset <= 1'b1; repeat (6) @(posedge clk_i); chk(busy, 1'b0);
        adc_reset <= 1'b0; busy_len(n); chk(n, 250);
    endtask
    task ser_t;
        mode <= 2'h3; code <= 18'h1C3A5; ach_host_i.start; busy_len(n);
        ach_host_i.sel(1); ach_host_i.shift(18, bits);
        chk(data_oe[9:0], 10'h0); ach_host_i.sel(0);
        chk(bits, 18'h1C3A5); chk(sclk_oe, 1'b0);
        ach_host_i.start; busy_len(n); ach_host_i.sel(1);
        ach_host_i.shift(5, bits); ach_host_i.start; busy_len(n);
        n = 0;
        repeat (12) @(posedge clk_i) if (data[13] === 1'b1) n = 1;
        chk(n, 1); ach_host_i.sel(0);
        wb(0, 8'h0C, 0); chk(rdat & 32'h2, 32'h2);
        src_sel <= 1'b0; repeat (4) @(posedge clk_i);
        chk(sclk_oe, 1'b1); src_sel <= 1'b1;
    endtask
    // slave read shifting on the falling serial clock
    task inv_t;
        inv <= 1'b1; code <= 18'h0B6C3; ach_host_i.start; busy_len(n);
        ach_host_i.sel(1); ach_host_i.shift(18, bits); ach_host_i.sel(0);
        chk(bits, 18'h0B6C3); inv <= 1'b0;
    endtask
    // master read: one bit taken at each rising clock the block drives
    task mst_t;
        logic prev;
        prev = 1'b0;
        src_sel <= 1'b0; code <= 18'h25A5C; ach_host_i.start; busy_len(n);
        n = 0;
        bits = 18'h0;
        ach_host_i.sel(1);
        repeat (120) begin
            @(posedge clk_i);
            if (sclk_out && !prev) begin
                bits = {bits[16:0], sdo};
                n++;
            end
            prev = sclk_out;
        end
        ach_host_i.sel(0); src_sel <= 1'b1;
        chk(bits, 18'h25A5C); chk(n, 18);
    endtask
    // main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        regs_t;
        ref_t;
        conv_t;
        par_t;
        pd_t;
        rst_t;
        ser_t;
        inv_t;
        mst_t;
        conclude;
    end
endmodule // adc_conversion_host_control_test
